// File: tscp_pkg.sv
package tscp_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ = 50_000_000;
    localparam int SCL_MAX_HZ = 400_000;
    // Quarter of an SCL period, rounded up so SCL never runs too fast
    localparam int QTR_CYCLES = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);

    // ==========================================================
    // Wishbone register offsets (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFS_SLAVE = 8'h00;
    localparam logic [7:0] OFS_REGPTR = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [2:0] OFS_BUF_HI = 3'h1;
    localparam int BUF_DEPTH = 8;

    // Control and status field positions
    localparam int CTRL_WRITE_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_NACK_BIT = 2;
    localparam int STAT_REFUSED_BIT = 3;

    // ==========================================================
    // Device side map
    // ==========================================================
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h18;
    localparam logic [3:0] DEV_PCAP = 4'h8;
    localparam logic [3:0] DEV_ROMSEL = 4'h9;
    localparam logic [3:0] DEV_RSVD = 4'ha;
    localparam logic [3:0] DEV_ROMDATA = 4'hb;
    localparam logic [3:0] DEV_STATUS = 4'hc;
    localparam int PCAP_RSVD_BIT = 6;
    localparam int PCAP_LOAD_BIT = 7;
    localparam logic [7:0] ROMSEL_KEEP = 8'h0f;
    localparam int STAT_POR_BIT = 7;
    localparam int STAT_LOCK_LSB = 4;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} tscp_state_t;
    typedef enum logic [2:0] {
        PH_ADDR_W, PH_REG, PH_WDATA, PH_ADDR_R, PH_RDATA
    } tscp_phase_t;

    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } tscp_pins_t;

    typedef struct packed {
        logic refused;
        logic nack;
        logic done;
        logic busy;
    } tscp_stat_t;

endpackage

// File: tscp_tick.sv
`timescale 1ns/1ps

// Quarter-period enable for the serial clock; idle while not running
module tscp_tick #(
    parameter int CYCLES = tscp_pkg::QTR_CYCLES
) (
    input wire logic clk_i,   // System clock
    input wire logic rst_i,   // Synchronous reset
    input wire logic run_i,   // Count while high
    output logic tick_o       // One-cycle enable pulse
);
    localparam int W = $clog2(CYCLES);

    logic [W-1:0] cnt;
    wire wrap = (cnt == W'(CYCLES - 1));

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            cnt <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt <= wrap ? '0 : cnt + W'(1);
            tick_o <= wrap;
        end
    end
endmodule

// File: tscp_host.sv
`timescale 1ns/1ps

// Functional notes
// RULE_01: Writing load strobe 0 to 1 loads readback with the selected ROM entry.
// RULE_02: Parallel cap code is bits 5-0; bit 6 reserved, host writes zero.
// RULE_03: ROM entry select is bits 3-0; host writes upper four bits zero.
// RULE_04: Host never writes the reserved register at address 1010b.
// RULE_05: Device presents the loaded ROM readback byte for reading.
// RULE_06: Power-up flag, status bit 7, set at power reset, cleared by read.
// RULE_07: Lock field 6-4: 000 go lower, 001-110 locked, 111 go higher.
// RULE_08: Device is slave; master starts transfers, SCL at most 400kHz.
// RULE_09: Each byte takes nine clocks: eight data bits and one ack bit.
// RULE_10: SDA stable while SCL high; changes then are START or STOP.
// RULE_11: START is SDA falling with SCL high; STOP is SDA rising.
// RULE_12: Ack: receiver holds SDA low across the ninth clock high phase.
// RULE_13: Nack: receiver leaves SDA high across the ninth clock high phase.
// RULE_14: Slave address is 11000 plus both straps; eighth bit is read/write.
// RULE_15: Device watches for START plus own address and acknowledges it.
// RULE_16: Write sends register address then data bytes MSB first, each acked.
// RULE_17: Device stores successive bytes in successive registers until STOP.
// RULE_18: Read: write address, register, repeated START, address with read bit.
// RULE_19: Device shifts read data out on rising SCL; tscp_dev_model shifts it out on falling SCL.
// RULE_20: Master acks to read on, or nacks last byte then sends STOP.
// RULE_21: On a failed transfer the master retries later; tscp_host does not retry, it sets the nack flag, sends STOP and then sets done.
// RULE_22: Idle bus: neither party pulls SDA or SCL low.
// RULE_23: Programmed ROM entry select moves that entry into readback.
// RULE_24: Device decodes low address nibble; above status ignored, reads zero.
module tscp_host (
    input wire logic clk_i,          // System clock, 50 MHz
    input wire logic rst_i,          // Synchronous reset, active high
    input wire logic wb_cyc_i,       // Wishbone cycle
    input wire logic wb_stb_i,       // Wishbone strobe
    input wire logic wb_we_i,        // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    output logic [31:0] wb_dat_o,    // Wishbone read data
    output logic wb_ack_o,           // Wishbone acknowledge
    input wire logic scl_i,          // Serial clock line level
    output logic scl_o,              // Serial clock drive level, always low
    output logic scl_oe_o,           // High while pulling serial clock low
    input wire logic sda_i,          // Serial data line level
    output logic sda_o,              // Serial data drive level, always low
    output logic sda_oe_o            // High while pulling serial data low
);
    // ==========================================================
    // Helpers
    // ==========================================================
    // Force reserved bits of a data byte to zero for its target
    function automatic logic [7:0] clean_byte(input logic [3:0] a,
                                              input logic [7:0] b);
        logic [7:0] r;
        r = b;
        if (a == tscp_pkg::DEV_PCAP)
            r[tscp_pkg::PCAP_RSVD_BIT] = 1'b0;            // [RULE_02]
        if (a == tscp_pkg::DEV_ROMSEL)
            r = r & tscp_pkg::ROMSEL_KEEP;                // [RULE_03]
        return r;
    endfunction

    // True when a write burst would touch the reserved register
    function automatic logic hits_rsvd(input logic [3:0] a,
                                       input logic [2:0] n_m1);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < tscp_pkg::BUF_DEPTH; i++)
            if (i <= int'(n_m1) && (a + 4'(i)) == tscp_pkg::DEV_RSVD)
                hit = 1'b1;
        return hit;
    endfunction

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];

    always_ff @(posedge clk_i)
    begin
        scl_sync <= {scl_sync[0], scl_i};
        sda_sync <= {sda_sync[0], sda_i};
    end

    // ==========================================================
    // State
    // ==========================================================
    tscp_pkg::tscp_state_t state;
    tscp_pkg::tscp_phase_t phase;
    tscp_pkg::tscp_stat_t stat;
    tscp_pkg::tscp_pins_t pins;
    tscp_pkg::tscp_pins_t next_pins;
    logic [1:0] strap;
    logic [7:0] reg_ptr;
    logic [2:0] cnt_m1;
    logic [7:0] buf_mem [tscp_pkg::BUF_DEPTH];
    logic op_read;
    logic in_frame;
    logic [1:0] q;
    logic [3:0] bit_cnt;
    logic [2:0] idx;
    logic [7:0] tx;
    logic [7:0] rx;
    logic ack_in;
    logic tick;

    tscp_tick #(.CYCLES(tscp_pkg::QTR_CYCLES)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(stat.busy),
        .tick_o(tick)
    );

    // ==========================================================
    // Wishbone decode
    // ==========================================================
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
    wire hit_slave = (wb_adr_i == tscp_pkg::OFS_SLAVE);
    wire hit_ptr = (wb_adr_i == tscp_pkg::OFS_REGPTR);
    wire hit_cnt = (wb_adr_i == tscp_pkg::OFS_COUNT);
    wire hit_ctrl = (wb_adr_i == tscp_pkg::OFS_CTRL);
    wire hit_stat = (wb_adr_i == tscp_pkg::OFS_STATUS);
    wire hit_buf = (wb_adr_i[7:5] == tscp_pkg::OFS_BUF_HI)
                   && (wb_adr_i[1:0] == 2'h0);
    wire [2:0] buf_idx = wb_adr_i[4:2];
    wire cfg_wr = wb_wr & ~stat.busy;
    wire go_write = cfg_wr & hit_ctrl & wb_dat_i[tscp_pkg::CTRL_WRITE_BIT];
    wire go_read = cfg_wr & hit_ctrl & wb_dat_i[tscp_pkg::CTRL_READ_BIT]
                   & ~wb_dat_i[tscp_pkg::CTRL_WRITE_BIT];
    wire rsvd_hit = hits_rsvd(reg_ptr[3:0], cnt_m1);
    wire refuse_set = go_write & rsvd_hit;                // [RULE_04]
    wire start_ok = (go_write & ~rsvd_hit) | go_read;
    wire stat_clr = wb_wr & hit_stat;

    wire [31:0] rd_val =
        hit_slave ? {30'h0, strap} :
        hit_ptr ? {24'h0, reg_ptr} :
        hit_cnt ? {29'h0, cnt_m1} :
        hit_stat ? {28'h0, stat} :
        hit_buf ? {24'h0, buf_mem[buf_idx]} : 32'h0;

    // ==========================================================
    // Bit engine decode
    // ==========================================================
    // Hold the high quarter until SCL is really high
    wire adv = tick & ~(q == 2'd1 && !scl_s);
    wire q_end = adv & (q == 2'd3);
    wire is_ack = (bit_cnt == 4'd8);
    wire rx_phase = (phase == tscp_pkg::PH_RDATA);
    wire last_rd = (idx == cnt_m1);
    wire byte_end = (state == tscp_pkg::ST_BIT) & q_end & is_ack;
    wire nack_set = byte_end & ack_in & ~rx_phase;        // [RULE_21]
    wire done_set = (state == tscp_pkg::ST_STOP) & q_end;
    wire rd_store = byte_end & rx_phase;
    wire [2:0] idx_nx = idx + 3'd1;
    wire [3:0] nx_reg = reg_ptr[3:0] + {1'b0, idx_nx};
    wire [7:0] addr_w = {tscp_pkg::SLAVE_ADDR_HI, strap, 1'b0}; // [RULE_14]
    wire [7:0] addr_r = {tscp_pkg::SLAVE_ADDR_HI, strap, 1'b1}; // [RULE_18]

    always_comb
    begin
        next_pins = '0;
        case (state)
            tscp_pkg::ST_START:
            begin
                // Release SDA under low SCL, then fall SDA with SCL high
                next_pins.scl_oe = (q == 2'd0) ? in_frame : (q == 2'd3);
                next_pins.sda_oe = (q >= 2'd2);           // [RULE_11]
            end
            tscp_pkg::ST_BIT:
            begin
                next_pins.scl_oe = (q == 2'd0) || (q == 2'd3);
                if (!is_ack)
                    next_pins.sda_oe = ~rx_phase & ~tx[7]; // [RULE_16]
                else
                    next_pins.sda_oe = rx_phase & ~last_rd; // [RULE_12] [RULE_13] [RULE_20]
            end
            tscp_pkg::ST_STOP:
            begin
                next_pins.scl_oe = (q == 2'd0);
                next_pins.sda_oe = (q <= 2'd1);           // [RULE_11]
            end
            default:
                next_pins = '0;                           // [RULE_22]
        endcase
    end

    // ==========================================================
    // Register file and pins
    // ==========================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            pins <= '0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req & ~wb_we_i) ? rd_val : 32'h0;
            pins <= next_pins;
        end
    end

    assign scl_oe_o = pins.scl_oe;
    assign sda_oe_o = pins.sda_oe;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            strap <= 2'h0;
            reg_ptr <= 8'h0;
            cnt_m1 <= 3'h0;
        end
        else if (cfg_wr)
        begin
            if (hit_slave)
                strap <= wb_dat_i[1:0];
            if (hit_ptr)
                reg_ptr <= wb_dat_i[7:0];
            if (hit_cnt)
                cnt_m1 <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rd_store)
            buf_mem[idx] <= rx;
        else if (cfg_wr && hit_buf)
            buf_mem[buf_idx] <= wb_dat_i[7:0];
    end

    // Sticky flags: an event in the clearing cycle wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat.done <= 1'b0;
            stat.nack <= 1'b0;
            stat.refused <= 1'b0;
        end
        else
        begin
            stat.done <= done_set
                | (stat.done & ~(stat_clr & wb_dat_i[tscp_pkg::STAT_DONE_BIT]));
            stat.nack <= nack_set
                | (stat.nack & ~(stat_clr & wb_dat_i[tscp_pkg::STAT_NACK_BIT]));
            stat.refused <= refuse_set
                | (stat.refused
                   & ~(stat_clr & wb_dat_i[tscp_pkg::STAT_REFUSED_BIT]));
        end
    end

    // ==========================================================
    // Transfer sequencer
    // ==========================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= tscp_pkg::ST_IDLE;
            phase <= tscp_pkg::PH_ADDR_W;
            stat.busy <= 1'b0;
            op_read <= 1'b0;
            in_frame <= 1'b0;
            q <= 2'd0;
            bit_cnt <= 4'd0;
            idx <= 3'd0;
            tx <= 8'h0;
            rx <= 8'h0;
            ack_in <= 1'b1;
        end
        else
        begin
            case (state)
                tscp_pkg::ST_IDLE:
                    if (start_ok)
                    begin
                        state <= tscp_pkg::ST_START;      // [RULE_08]
                        phase <= tscp_pkg::PH_ADDR_W;
                        stat.busy <= 1'b1;
                        op_read <= go_read;
                        tx <= addr_w;
                        idx <= 3'd0;
                        q <= 2'd0;
                    end
                tscp_pkg::ST_START:
                    if (adv)
                    begin
                        q <= q + 2'd1;
                        if (q == 2'd3)
                        begin
                            state <= tscp_pkg::ST_BIT;
                            bit_cnt <= 4'd0;
                            in_frame <= 1'b1;
                        end
                    end
                tscp_pkg::ST_BIT:
                    if (adv)
                    begin
                        q <= q + 2'd1;
                        if (q == 2'd2 && is_ack)
                            ack_in <= sda_s;
                        else if (q == 2'd2)
                            rx <= {rx[6:0], sda_s};       // [RULE_10]
                        if (q == 2'd3 && !is_ack)
                        begin
                            bit_cnt <= bit_cnt + 4'd1;    // [RULE_09]
                            tx <= {tx[6:0], 1'b0};
                        end
                        else if (q == 2'd3)
                        begin
                            bit_cnt <= 4'd0;
                            if (ack_in && !rx_phase)
                                state <= tscp_pkg::ST_STOP;
                            else
                                case (phase)
                                    tscp_pkg::PH_ADDR_W:
                                    begin
                                        phase <= tscp_pkg::PH_REG;
                                        tx <= reg_ptr;
                                    end
                                    tscp_pkg::PH_REG:
                                        if (op_read)
                                        begin
                                            state <= tscp_pkg::ST_START;
                                            phase <= tscp_pkg::PH_ADDR_R;
                                            tx <= addr_r; // [RULE_18]
                                        end
                                        else
                                        begin
                                            phase <= tscp_pkg::PH_WDATA;
                                            tx <= clean_byte(reg_ptr[3:0],
                                                             buf_mem[0]);
                                        end
                                    tscp_pkg::PH_WDATA:
                                        if (last_rd)
                                            state <= tscp_pkg::ST_STOP;
                                        else
                                        begin
                                            idx <= idx_nx;
                                            tx <= clean_byte(nx_reg,
                                                             buf_mem[idx_nx]);
                                        end
                                    tscp_pkg::PH_ADDR_R:
                                        phase <= tscp_pkg::PH_RDATA;
                                    tscp_pkg::PH_RDATA:
                                        if (last_rd)
                                            state <= tscp_pkg::ST_STOP; // [RULE_20]
                                        else
                                            idx <= idx_nx;
                                    default:
                                        state <= tscp_pkg::ST_STOP;
                                endcase
                        end
                    end
                tscp_pkg::ST_STOP:
                    if (adv)
                    begin
                        q <= q + 2'd1;
                        if (q == 2'd3)
                        begin
                            state <= tscp_pkg::ST_IDLE;
                            stat.busy <= 1'b0;
                            in_frame <= 1'b0;
                        end
                    end
                default:
                    state <= tscp_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_stop_end;
        state == tscp_pkg::ST_STOP && q_end;
    endsequence

    sequence s_bus_free;
        state == tscp_pkg::ST_IDLE ##1 (!sda_oe_o && !scl_oe_o);
    endsequence

    AST_IDLE_RELEASE: assert property (s_stop_end |=> s_bus_free) // [RULE_22]
        else $error("bus not released after stop");
    AST_START_FALL: assert property ( // [RULE_11]
        (state == tscp_pkg::ST_START && q == 2'd2) |=> (sda_oe_o && !scl_oe_o))
        else $error("start not formed with SCL high");
    AST_SDA_STABLE: assert property ( // [RULE_10]
        (state == tscp_pkg::ST_BIT && q == 2'd2 && !scl_oe_o)
        |=> $stable(sda_oe_o))
        else $error("SDA moved while SCL high");
    AST_MSB_FIRST: assert property ( // [RULE_16]
        (state == tscp_pkg::ST_BIT && !is_ack && !rx_phase && q == 2'd0)
        |=> (sda_oe_o == ~$past(tx[7])))
        else $error("data bit not MSB first");
    AST_ACK_HOLD: assert property ( // [RULE_12]
        (state == tscp_pkg::ST_BIT && is_ack && rx_phase && !last_rd
         && q == 2'd1) |=> sda_oe_o)
        else $error("host ack not driven");
    AST_NACK_LAST: assert property ( // [RULE_13]
        (state == tscp_pkg::ST_BIT && is_ack && rx_phase && last_rd
         && q == 2'd1) |=> !sda_oe_o)
        else $error("last read byte not nacked");
    AST_NINE_BITS: assert property ( // [RULE_09]
        (state == tscp_pkg::ST_BIT && is_ack && q_end)
        |=> (bit_cnt == 4'd0))
        else $error("byte did not end after ninth bit");
    AST_TICK_GAP: assert property (tick |=> (!tick) [*8]) // [RULE_08]
        else $error("serial clock quarter too short");
    AST_REFUSE_RSVD: assert property ( // [RULE_04]
        refuse_set |=> (state == tscp_pkg::ST_IDLE && stat.refused))
        else $error("reserved register write not refused");
    AST_SLAVE_ADDR: assert property ( // [RULE_14]
        start_ok |=> (tx[7:3] == tscp_pkg::SLAVE_ADDR_HI && tx[2:1] == strap))
        else $error("slave address malformed");
    AST_WB_ACK: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not single cycle");
endmodule

// File: tscp_dev_model.sv
`timescale 1ns/1ps
// Behavioural tuner port, slave on the two-wire link
module tscp_dev_model (
    input wire logic scl_i,         // Resolved clock line
    input wire logic sda_i,         // Resolved data line
    input wire logic [1:0] strap_i, // Address straps
    input wire logic [2:0] lock_i,  // PLL lock code
    input wire logic slow_i,        // Stretch clock low phases
    output logic scl_oe_o,          // Pulls clock low
    output logic sda_oe_o,          // Pulls data low
    output logic [7:0] bad_o        // Host breaches seen
);
    logic [7:0] regs [8:12];
    logic [7:0] sh, tx;
    logic [3:0] ptr;
    logic act, rd, first, regb, mack, por;
    int n;
    // ======================
    // Register side
    task automatic load();
        tx = 8'h00;
        if (ptr >= 4'h8 && ptr <= 4'hc) tx = regs[ptr];
        if (ptr == 4'hc)
        begin
            tx = {por, lock_i, 4'h0};
            por = 1'b0;
        end
        sda_oe_o = !tx[7];
        ptr++;
    endtask
    task automatic store();
        if (ptr == 4'h8 && sh[7] && !regs[8][7])
            regs[11] = {regs[9][3:0], ~regs[9][3:0]};
        if ((ptr == 4'h8 && sh[6]) || (ptr == 4'h9 && sh[7:4] != 4'h0))
            bad_o++;
        if (ptr == 4'ha) bad_o++;
        if (ptr == 4'h9) regs[11] = {sh[3:0], ~sh[3:0]};
        if (ptr >= 4'h8 && ptr <= 4'ha) regs[ptr] = sh;
        ptr++;
    endtask
    initial
    begin
        {scl_oe_o, sda_oe_o, act, rd, bad_o} = '0;
        por = 1'b1;
        for (int i = 8; i <= 12; i++) regs[i] = 8'h00;
    end
    // ======================
    // Link side
    always @(negedge sda_i)
        if (scl_i === 1'b1)
        begin
            act = 1'b1;
            first = 1'b1;
            n = 0;
        end
    always @(posedge sda_i)
        if (scl_i === 1'b1)
        begin
            act = 1'b0;
            sda_oe_o = 1'b0;
        end
    always @(posedge scl_i)
        if (act)
        begin
            if (n < 8) sh = {sh[6:0], sda_i};
            if (n == 8) mack = !sda_i;
            n++;
        end
    always @(negedge scl_i)
        if (slow_i && act)
        begin
            scl_oe_o = 1'b1;
            #1000 scl_oe_o = 1'b0;
        end
    always @(negedge scl_i)
        if (act && n == 8)
        begin
            sda_oe_o = !(rd && !first);
            if (first && sh[7:1] != {5'h18, strap_i})
                {act, sda_oe_o} = 2'b00;
            else if (first)
                {rd, regb} = {sh[0], !sh[0]};
            else if (regb)
                {regb, ptr} = {1'b0, sh[3:0]};
            else if (!rd)
                store();
        end
        else if (act && n == 9)
        begin
            n = 0;
            sda_oe_o = 1'b0;
            if (rd && (first || mack)) load();
            first = 1'b0;
        end
        else if (act && rd && !first && n > 0)
            sda_oe_o = !tx[7 - n];
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, h_scl, h_sda, d_scl, d_sda, slow = 1'b0;
    logic h_so, h_co;
    logic [2:0] lock = 3'h0;
    logic [7:0] bad;
    logic [7:0] rexp [5] = '{8'hbf, 8'h05, 8'h00, 8'h5a, 8'hb0};
    logic [2:0] lcode [3] = '{3'h0, 3'h6, 3'h7};
    int fails = 0, samples_checked = 0;
    wire scl = !h_scl && !d_scl;
    wire sda = !h_sda && !d_sda;
    always #10 clk_i = ~clk_i;
    tscp_host tscp_host_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl), .scl_o(h_co),
        .scl_oe_o(h_scl), .sda_i(sda), .sda_o(h_so), .sda_oe_o(h_sda));
    tscp_dev_model tscp_dev_model_inst (.scl_i(scl), .sda_i(sda),
        .strap_i(2'b10), .lock_i(lock), .slow_i(slow), .scl_oe_o(d_scl),
        .sda_oe_o(d_sda), .bad_o(bad));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic tmo();
        chk("wait_bound", 32'h0, 32'h1);
        end_sim();
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int k;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (k == 20) tmo();
    endtask
    task automatic op(input logic [7:0] p, c, m);
        int k;
        wb(tscp_pkg::OFS_STATUS, 1'b1, 8'h0e);
        wb(tscp_pkg::OFS_REGPTR, 1'b1, p);
        wb(tscp_pkg::OFS_COUNT, 1'b1, c);
        wb(tscp_pkg::OFS_CTRL, 1'b1, m);
        for (k = 0; k < 9000 && (q[1] | q[3]) !== 1'b1; k++)
            wb(tscp_pkg::OFS_STATUS, 1'b0, 8'h00);
        if (k == 9000) tmo();
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(tscp_pkg::OFS_STATUS, 1'b0, 8'h00);
        chk("status_rst", q, 32'h0);
        wb(8'h40, 1'b0, 8'h00);
        chk("unmapped", q, 32'h0);
        wb(tscp_pkg::OFS_SLAVE, 1'b1, 8'h02);
        wb(8'h20, 1'b1, 8'hff);
        wb(8'h24, 1'b1, 8'hf5);
        op(8'h08, 8'h01, 8'h01);
        chk("wr_status", q, 32'h2);
        chk("breaches", bad, 32'h0);
        chk("idle", {scl, sda}, 32'h3);
        chk("drive_level", {h_co, h_so}, 32'h0);
        $display("test write done");
        slow <= 1'b1;
        lock <= 3'h3;
        op(8'h08, 8'h04, 8'h02);
        slow <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            wb(8'h20 + 8'(4 * i), 1'b0, 8'h00);
            chk("rd_byte", q, {24'h0, rexp[i]});
        end
        $display("test burst read done");
        foreach (lcode[i])
        begin
            lock <= lcode[i];
            op(8'h0c, 8'h00, 8'h02);
            wb(8'h20, 1'b0, 8'h00);
            chk("lock_status", q, {25'h0, lcode[i], 4'h0});
        end
        $display("test status done");
        op(8'h09, 8'h01, 8'h01);
        chk("refused", q, 32'h8);
        wb(tscp_pkg::OFS_SLAVE, 1'b1, 8'h01);
        op(8'h08, 8'h00, 8'h01);
        chk("nack", q, 32'h6);
        chk("breaches", bad, 32'h0);
        $display("test refusal done");
        end_sim();
    end
endmodule
